/* hw/srre_addr_add.sv */
// Stack address adder: base plus or minus a byte offset.
`timescale 1ns/1ps
`default_nettype none
module srre_addr_add (
	// Operands
	input wire logic [15:0] base,
	input wire logic [15:0] offset,
	input wire logic subtract,
	// Result
	output logic [15:0] addr
);
	assign addr = subtract ? (base - offset) : (base + offset);
endmodule : srre_addr_add
`default_nettype wire

/* hw/srre_core.sv */
// Execution of pushes, frame preparation, repeat prefixes and returns.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module srre_core (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Command
	input wire logic cmd_valid,
	input wire srre_pkg::srre_cmd_s cmd,
	output logic cmd_ready,
	output logic done,
	// Block step unit
	output logic blk_go,
	input wire srre_pkg::srre_blk_s blk,
	// Interrupt
	input wire logic irq_req,
	input wire logic emu_entry,
	output logic irq_take,
	// Stack memory
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [15:0] mem_rdata,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [15:0] reg_rdata,
	// Mode
	output logic native_mode_flag
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_PUSH, ST_POP, ST_PREP_BP, ST_PREP_RD, ST_PREP_WR,
		ST_PREP_TMP, ST_REP_CHK, ST_REP_WAIT
	} srre_st_e;

	srre_st_e st_r, st_nxt;
	srre_pkg::srre_cmd_s cmd_r, cmd_nxt;
	logic [15:0] gpr_r [srre_pkg::GPR_NUM];
	logic [15:0] gpr_nxt [srre_pkg::GPR_NUM];
	logic [15:0] pc_r, pc_nxt, ps_r, ps_nxt, status_word, psw_nxt;
	logic [15:0] tmp_r, tmp_nxt, reg_rdata_nxt;
	logic [7:0] step_r, step_nxt;
	logic md_wen_r, wen_nxt, done_r, done_nxt, take_r, take_nxt;

	// ==========================================================
	// Decode helpers
	function automatic logic [7:0] push_words(input srre_pkg::srre_op_e op);
		push_words = (op == srre_pkg::OP_PUSH_ALL) ? srre_pkg::PUSH_ALL_WORDS :
			srre_pkg::PUSH_ONE_WORDS;
	endfunction : push_words

	function automatic logic [7:0] pop_words(input srre_pkg::srre_op_e op);
		case (op)
			srre_pkg::OP_RET_FAR: pop_words = srre_pkg::POP_FAR_WORDS;
			srre_pkg::OP_RET_EMU: pop_words = srre_pkg::POP_EMU_WORDS;
			default: pop_words = srre_pkg::POP_NEAR_WORDS;
		endcase
	endfunction : pop_words

	function automatic logic rep_stop(input srre_pkg::srre_rep_e k, input logic z,
		input logic c);
		case (k)
			srre_pkg::REP_EQ: rep_stop = !z;
			srre_pkg::REP_NE: rep_stop = z;
			srre_pkg::REP_C: rep_stop = !c;
			srre_pkg::REP_NC: rep_stop = c;
			default: rep_stop = 1'b0;
		endcase
	endfunction : rep_stop

	// ==========================================================
	// Named wires
	wire logic [15:0] sp = gpr_r[srre_pkg::GPR_SP];
	wire logic [15:0] bp = gpr_r[srre_pkg::GPR_BP];
	wire logic [15:0] count = gpr_r[srre_pkg::GPR_CNT];
	wire logic [7:0] step_p1 = step_r + 8'h01;
	wire logic [7:0] pop_cnt = pop_words(cmd_r.op);
	wire logic [7:0] push_cnt = push_words(cmd_r.op);
	wire logic [15:0] count_dec = count - 16'h0001;
	wire logic [15:0] push_off = {7'h00, step_p1, 1'b0};
	wire logic [15:0] pop_off = {7'h00, step_r, 1'b0};
	wire logic [15:0] rep_next_pc = cmd_r.prefix_pc + srre_pkg::REP_NEXT_OFS;
	wire logic ret_imm = (cmd_r.op != srre_pkg::OP_RET_EMU);
	wire logic [15:0] pop_adj = {7'h00, pop_cnt, 1'b0} + (ret_imm ? cmd_r.imm16 :
		srre_pkg::WORD_RST);
	wire logic [15:0] imm8_sext = {{8{cmd_r.imm8[7]}}, cmd_r.imm8};
	wire logic [15:0] push_word = (cmd_r.op == srre_pkg::OP_PUSH_IMM8) ? imm8_sext : cmd_r.word;
	wire logic [15:0] addr_off = (st_r == ST_PUSH) ? push_off :
		(st_r == ST_POP) ? pop_off : srre_pkg::STACK_WORD;
	wire logic [15:0] addr_base = (st_r == ST_PREP_RD) ? bp : sp;
	wire logic idle = (st_r == ST_IDLE);
	wire logic [7:0] lvl = cmd_r.imm8;

	srre_addr_add u_addr (
		.base(addr_base),
		.offset(addr_off),
		.subtract(st_r != ST_POP),
		.addr(mem_addr)
	);

	// ==========================================================
	// Memory and handshake outputs
	assign mem_we = (st_r == ST_PUSH) || (st_r == ST_PREP_BP) || (st_r == ST_PREP_WR) ||
		(st_r == ST_PREP_TMP);
	assign mem_re = ((st_r == ST_POP) && (step_r < pop_cnt)) || (st_r == ST_PREP_RD);
	assign mem_wdata = (st_r == ST_PUSH) ? ((cmd_r.op == srre_pkg::OP_PUSH_ALL) ?
		gpr_r[step_r[2:0]] : push_word) : (st_r == ST_PREP_BP) ? bp :
		(st_r == ST_PREP_WR) ? mem_rdata : (st_r == ST_PREP_TMP) ? tmp_r : srre_pkg::WORD_RST;
	assign blk_go = (st_r == ST_REP_CHK) && (count != srre_pkg::WORD_RST);
	assign cmd_ready = idle;
	assign done = done_r;
	assign irq_take = take_r;
	assign native_mode_flag = status_word[srre_pkg::PSW_MD_BIT];

	// ==========================================================
	// Register port read
	always_comb begin
		reg_rdata_nxt = srre_pkg::WORD_RST;
		if (reg_addr <= srre_pkg::REG_GPR_LAST) begin
			reg_rdata_nxt = gpr_r[reg_addr[2:0]];
		end else if (reg_addr == srre_pkg::REG_PC) begin
			reg_rdata_nxt = pc_r;
		end else if (reg_addr == srre_pkg::REG_PS) begin
			reg_rdata_nxt = ps_r;
		end else if (reg_addr == srre_pkg::REG_PSW) begin
			reg_rdata_nxt = status_word;
		end else if (reg_addr == srre_pkg::REG_STATUS) begin
			reg_rdata_nxt[srre_pkg::ST_BUSY_BIT] = !idle;
			reg_rdata_nxt[srre_pkg::ST_WEN_BIT] = md_wen_r;
			reg_rdata_nxt[srre_pkg::ST_MD_BIT] = native_mode_flag;
		end
	end

	// ==========================================================
	// Sequencer next state
	always_comb begin
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		step_nxt = step_r;
		tmp_nxt = tmp_r;
		pc_nxt = pc_r;
		ps_nxt = ps_r;
		psw_nxt = status_word;
		wen_nxt = md_wen_r || emu_entry;
		done_nxt = 1'b0;
		take_nxt = 1'b0;
		for (int i = 0; i < srre_pkg::GPR_NUM; i++) begin
			gpr_nxt[i] = gpr_r[i];
		end
		case (st_r)
			ST_IDLE: begin
				if (cmd_valid) begin
					cmd_nxt = cmd;
					step_nxt = 8'h00;
					case (cmd.op)
						srre_pkg::OP_PREPARE: st_nxt = ST_PREP_BP;
						srre_pkg::OP_REP: st_nxt = ST_REP_CHK;
						srre_pkg::OP_RET_NEAR, srre_pkg::OP_RET_FAR,
						srre_pkg::OP_RET_EMU: st_nxt = ST_POP;
						default: st_nxt = ST_PUSH;
					endcase
				end else if (reg_we) begin
					if (reg_addr <= srre_pkg::REG_GPR_LAST) begin
						gpr_nxt[reg_addr[2:0]] = reg_wdata;
					end else if (reg_addr == srre_pkg::REG_PC) begin
						pc_nxt = reg_wdata;
					end else if (reg_addr == srre_pkg::REG_PS) begin
						ps_nxt = reg_wdata;
					end else if (reg_addr == srre_pkg::REG_PSW) begin
						psw_nxt = reg_wdata;
						if (!md_wen_r) begin
							psw_nxt[srre_pkg::PSW_MD_BIT] = status_word[srre_pkg::PSW_MD_BIT];
						end
					end
				end
			end
			ST_PUSH: begin
				if (step_p1 == push_cnt) begin
					gpr_nxt[srre_pkg::GPR_SP] = sp - {7'h00, push_cnt, 1'b0};
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end else begin
					step_nxt = step_p1;
				end
			end
			ST_POP: begin
				case (step_r)
					8'h01: pc_nxt = mem_rdata;
					8'h02: ps_nxt = mem_rdata;
					8'h03: psw_nxt = mem_rdata;
					default: ;
				endcase
				if (step_r == pop_cnt) begin
					gpr_nxt[srre_pkg::GPR_SP] = sp + pop_adj;
					if (cmd_r.op == srre_pkg::OP_RET_EMU) begin
						wen_nxt = 1'b0;
					end
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end else begin
					step_nxt = step_p1;
				end
			end
			ST_PREP_BP: begin
				tmp_nxt = sp - srre_pkg::STACK_WORD;
				if (lvl == 8'h00) begin
					gpr_nxt[srre_pkg::GPR_BP] = sp - srre_pkg::STACK_WORD;
					gpr_nxt[srre_pkg::GPR_SP] = sp - srre_pkg::STACK_WORD - cmd_r.imm16;
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end else begin
					gpr_nxt[srre_pkg::GPR_SP] = sp - srre_pkg::STACK_WORD;
					st_nxt = (lvl > 8'h01) ? ST_PREP_RD : ST_PREP_TMP;
				end
			end
			ST_PREP_RD: begin
				gpr_nxt[srre_pkg::GPR_BP] = bp - srre_pkg::STACK_WORD;
				st_nxt = ST_PREP_WR;
			end
			ST_PREP_WR: begin
				gpr_nxt[srre_pkg::GPR_SP] = sp - srre_pkg::STACK_WORD;
				step_nxt = step_p1;
				st_nxt = (step_p1 < lvl - 8'h01) ? ST_PREP_RD : ST_PREP_TMP;
			end
			ST_PREP_TMP: begin
				gpr_nxt[srre_pkg::GPR_BP] = tmp_r;
				gpr_nxt[srre_pkg::GPR_SP] = sp - srre_pkg::STACK_WORD - cmd_r.imm16;
				done_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
			ST_REP_CHK: begin
				if (count == srre_pkg::WORD_RST) begin
					pc_nxt = rep_next_pc;
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end else begin
					st_nxt = ST_REP_WAIT;
				end
			end
			ST_REP_WAIT: begin
				if (blk.done) begin
					gpr_nxt[srre_pkg::GPR_CNT] = count_dec;
					if ((count_dec == srre_pkg::WORD_RST) ||
						rep_stop(cmd_r.repeat_unconditional, blk.zero, blk.carry)) begin
						pc_nxt = rep_next_pc;
						done_nxt = 1'b1;
						st_nxt = ST_IDLE;
					end else if (irq_req) begin
						pc_nxt = cmd_r.prefix_pc;
						take_nxt = 1'b1;
						done_nxt = 1'b1;
						st_nxt = ST_IDLE;
					end else begin
						st_nxt = ST_REP_CHK;
					end
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= ST_IDLE;
			cmd_r <= '0;
			step_r <= 8'h00;
			tmp_r <= srre_pkg::WORD_RST;
			pc_r <= srre_pkg::WORD_RST;
			ps_r <= srre_pkg::WORD_RST;
			status_word <= srre_pkg::PSW_RST;
			md_wen_r <= srre_pkg::MD_WEN_RST;
			done_r <= 1'b0;
			take_r <= 1'b0;
			reg_rdata <= srre_pkg::WORD_RST;
			for (int i = 0; i < srre_pkg::GPR_NUM; i++) begin
				gpr_r[i] <= srre_pkg::WORD_RST;
			end
		end else begin
			st_r <= st_nxt;
			cmd_r <= cmd_nxt;
			step_r <= step_nxt;
			tmp_r <= tmp_nxt;
			pc_r <= pc_nxt;
			ps_r <= ps_nxt;
			status_word <= psw_nxt;
			md_wen_r <= wen_nxt;
			done_r <= done_nxt;
			take_r <= take_nxt;
			reg_rdata <= reg_re ? reg_rdata_nxt : srre_pkg::WORD_RST;
			for (int i = 0; i < srre_pkg::GPR_NUM; i++) begin
				gpr_r[i] <= gpr_nxt[i];
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence pushall_run;
		(st_r == ST_PUSH) [*8];
	endsequence

	wire logic rep_ends = (st_r == ST_REP_WAIT) && blk.done;

	push_imm_sext_a: assert property ((st_r == ST_PUSH) && (cmd_r.op == srre_pkg::OP_PUSH_IMM8)
		|-> mem_we && (mem_wdata == {{8{cmd_r.imm8[7]}}, cmd_r.imm8}))
		else $error("immediate push not sign-extended");
	push_one_addr_a: assert property ((st_r == ST_PUSH) && (cmd_r.op == srre_pkg::OP_PUSH)
		|-> (mem_addr == sp - 16'h0002) ##1 (sp == $past(sp) - 16'h0002))
		else $error("single push address or stack pointer wrong");
	push_all_sp_a: assert property (idle && cmd_valid && (cmd.op == srre_pkg::OP_PUSH_ALL)
		|=> pushall_run ##1 (sp == $past(sp, 9) - 16'h0010))
		else $error("push-all sequence or stack drop wrong");
	rep_count_dec_a: assert property (rep_ends |=> count == $past(count) - 16'h0001)
		else $error("repeat count not decremented");
	rep_all_loop_a: assert property (rep_ends && (cmd_r.repeat_unconditional == srre_pkg::REP_ALL) &&
		(count > 16'h0001) && !irq_req |=> (st_r == ST_REP_CHK) && blk_go)
		else $error("unconditional repeat stopped early");
	rep_flag_exit_a: assert property (rep_ends && rep_stop(cmd_r.repeat_unconditional, blk.zero, blk.carry)
		|=> idle && done && (pc_r == $past(cmd_r.prefix_pc) + 16'h0002))
		else $error("conditional repeat did not exit");
	rep_zero_skip_a: assert property ((st_r == ST_REP_CHK) && (count == 16'h0000)
		|-> !blk_go ##1 (idle && done))
		else $error("zero count did not skip block");
	irq_hold_a: assert property (irq_take |-> $past(st_r) == ST_REP_WAIT && $past(blk.done)
		&& (pc_r == cmd_r.prefix_pc))
		else $error("interrupt taken at wrong point");
	ret_near_sp_a: assert property ((st_r == ST_POP) && (cmd_r.op == srre_pkg::OP_RET_NEAR) &&
		(step_r == 8'h01) |=> sp == $past(sp) + 16'h0002 + $past(cmd_r.imm16))
		else $error("near return stack adjust wrong");
	ret_far_sp_a: assert property ((st_r == ST_POP) && (cmd_r.op == srre_pkg::OP_RET_FAR) &&
		(step_r == 8'h02) |=> sp == $past(sp) + 16'h0004 + $past(cmd_r.imm16))
		else $error("far return stack adjust wrong");
	ret_emu_lock_a: assert property ((st_r == ST_POP) && (cmd_r.op == srre_pkg::OP_RET_EMU) &&
		(step_r == 8'h03) |=> !md_wen_r && (sp == $past(sp) + 16'h0006))
		else $error("emulation return did not lock mode");
endmodule : srre_core
`default_nettype wire

/* hw/srre_pkg.sv */
// Shared types and constants for the stack, return and repeat execution block.
package srre_pkg;

	// ==========================================================
	// Register port indexes
	localparam logic [3:0] REG_PC = 4'h8;
	localparam logic [3:0] REG_PS = 4'h9;
	localparam logic [3:0] REG_PSW = 4'ha;
	localparam logic [3:0] REG_STATUS = 4'hb;
	localparam logic [3:0] REG_GPR_LAST = 4'h7;

	// ==========================================================
	// General register slots, in push-all order
	localparam logic [2:0] GPR_ACC = 3'h0;
	localparam logic [2:0] GPR_CNT = 3'h1;
	localparam logic [2:0] GPR_SP = 3'h4;
	localparam logic [2:0] GPR_BP = 3'h5;
	localparam int GPR_NUM = 8;

	// ==========================================================
	// Field positions and reset values
	localparam int PSW_MD_BIT = 15;
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_WEN_BIT = 1;
	localparam int ST_MD_BIT = 0;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] PSW_RST = 16'h8000;
	localparam logic MD_WEN_RST = 1'b1;

	// ==========================================================
	// Stack and sequence counts
	localparam logic [15:0] STACK_WORD = 16'h0002;
	localparam logic [15:0] REP_NEXT_OFS = 16'h0002;
	localparam logic [7:0] PUSH_ONE_WORDS = 8'h01;
	localparam logic [7:0] PUSH_ALL_WORDS = 8'h08;
	localparam logic [7:0] POP_NEAR_WORDS = 8'h01;
	localparam logic [7:0] POP_FAR_WORDS = 8'h02;
	localparam logic [7:0] POP_EMU_WORDS = 8'h03;

	// ==========================================================
	// Commands and repeat kinds
	typedef enum logic [2:0] {
		OP_PUSH, OP_PUSH_IMM8, OP_PUSH_ALL, OP_PREPARE,
		OP_REP, OP_RET_NEAR, OP_RET_FAR, OP_RET_EMU
	} srre_op_e;

	typedef enum logic [2:0] {
		REP_ALL, REP_EQ, REP_NE, REP_C, REP_NC
	} srre_rep_e;

	typedef struct packed {
		srre_op_e op;
		srre_rep_e repeat_unconditional;
		logic [15:0] imm16;
		logic [7:0] imm8;
		logic [15:0] word;
		logic [15:0] prefix_pc;
	} srre_cmd_s;

	typedef struct packed {
		logic done;
		logic zero;
		logic carry;
	} srre_blk_s;

endpackage : srre_pkg

/* sim/srre_mem_model.sv */
// Behavioural stack memory on the far side of the execution core.
`timescale 1ns/1ps
`default_nettype none
module srre_mem_model (
	// Clock
	input wire logic clock,
	// Memory port
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [15:0] mem_rdata
);
	logic [15:0] store [0:32767];
	initial mem_rdata = 16'h5a5a;
	// ==========================================================
	// Read data stand one cycle only; otherwise the bus shows a changing pattern.
	always @(posedge clock) begin
		if (mem_we)
			store[mem_addr[15:1]] <= mem_wdata;
		if (mem_re)
			mem_rdata <= store[mem_addr[15:1]];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule : srre_mem_model
`default_nettype wire

/* sim/stack_return_repeat_exec_test.sv */
// Self-checking bench for the stack, return and repeat execution core.
`timescale 1ns/1ps
`default_nettype none
module stack_return_repeat_exec_test;
	logic clock, rst, cmd_valid, cmd_ready, done, blk_go, irq_req, emu_entry, irq_take;
	logic mem_we, mem_re, reg_we, reg_re, native_mode_flag, cont_z, cont_c, irq_seen;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, reg_wdata, reg_rdata, rd;
	logic [3:0] reg_addr;
	srre_pkg::srre_cmd_s cmd;
	srre_pkg::srre_blk_s blk;
	int bad_count, cmp_count, lat, step, stop_at;
	wire hit = (step + 1 == stop_at);

	srre_core dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .done(done), .blk_go(blk_go), .blk(blk), .irq_req(irq_req),
		.emu_entry(emu_entry), .irq_take(irq_take), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .native_mode_flag(native_mode_flag));
	srre_mem_model mem (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ==========================================================
	// Block step unit: answers each step one cycle later with scripted flags.
	always @(posedge clock) begin
		if (blk_go) begin
			step <= step + 1;
			blk <= {1'b1, hit ? ~cont_z : cont_z, hit ? ~cont_c : cont_c};
		end else
			blk <= {1'b0, ~cont_z, ~cont_c};
	end

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk16

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clock);
		reg_we <= 1'b0;
		#1;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clock);
		reg_re <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_rd

	task automatic put(input logic [15:0] a, input logic [15:0] d);
		mem.store[a[15:1]] = d;
	endtask : put

	function automatic srre_pkg::srre_cmd_s mk(input srre_pkg::srre_op_e op,
		input srre_pkg::srre_rep_e rp, input logic [15:0] i16, input logic [7:0] i8,
		input logic [15:0] w);
		return '{op, rp, i16, i8, w, 16'h0100};
	endfunction : mk

	task automatic run_cmd(input srre_pkg::srre_cmd_s c);
		@(posedge clock);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge clock);
		cmd_valid <= 1'b0;
		lat = 1;
		#1;
		while (done !== 1'b1 && lat < 300) begin
			@(posedge clock);
			#1;
			lat++;
		end
		irq_seen = irq_take;
		if (done !== 1'b1) begin
			bad_count++;
			$display("[FAIL] %0t command never finished", $time);
		end
	endtask : run_cmd

	task automatic t_reset();
		reg_rd(srre_pkg::REG_PSW, rd);
		chk16(rd, 16'h8000, "psw reset");
		reg_rd(srre_pkg::REG_STATUS, rd);
		chk16(rd, 16'h0003, "status reset");
		reg_wr(4'hf, 16'hbeef);
		reg_rd(4'hf, rd);
		chk16(rd, 16'h0000, "unmapped");
		$display("test reset done");
	endtask : t_reset

	task automatic t_push();
		reg_wr(4'h4, 16'h0100);
		run_cmd(mk(srre_pkg::OP_PUSH, srre_pkg::REP_ALL, 16'h0, 8'h0, 16'h1234));
		chk16(16'(lat), 16'h0002, "push latency");
		chk16(mem.store[16'h00fe >> 1], 16'h1234, "push word");
		run_cmd(mk(srre_pkg::OP_PUSH_IMM8, srre_pkg::REP_ALL, 16'h0, 8'h80, 16'h0));
		chk16(mem.store[16'h00fc >> 1], 16'hff80, "imm8 neg");
		run_cmd(mk(srre_pkg::OP_PUSH_IMM8, srre_pkg::REP_ALL, 16'h0, 8'h7f, 16'h0));
		chk16(mem.store[16'h00fa >> 1], 16'h007f, "imm8 pos");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h00fa, "push sp");
		$display("test push done");
	endtask : t_push

	task automatic t_push_all();
		for (int i = 0; i < 8; i++)
			reg_wr(4'(i), (i == 4) ? 16'h0200 : 16'h1000 + 16'(i));
		run_cmd(mk(srre_pkg::OP_PUSH_ALL, srre_pkg::REP_ALL, 16'h0, 8'h0, 16'h0));
		chk16(16'(lat), 16'h0009, "push all latency");
		for (int i = 0; i < 8; i++)
			chk16(mem.store[(16'h0200 - 16'(2 * i + 2)) >> 1],
				(i == 4) ? 16'h0200 : 16'h1000 + 16'(i), "push all word");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h01f0, "push all sp");
		$display("test push all done");
	endtask : t_push_all

	task automatic t_ret();
		reg_wr(4'h4, 16'h0700);
		put(16'h0700, 16'h5555);
		run_cmd(mk(srre_pkg::OP_RET_NEAR, srre_pkg::REP_ALL, 16'h0004, 8'h0, 16'h0));
		chk16(16'(lat), 16'h0003, "near latency");
		reg_rd(srre_pkg::REG_PC, rd);
		chk16(rd, 16'h5555, "near pc");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h0706, "near sp");
		reg_wr(4'h4, 16'h0600);
		put(16'h0600, 16'h3333);
		put(16'h0602, 16'h4444);
		run_cmd(mk(srre_pkg::OP_RET_FAR, srre_pkg::REP_ALL, 16'h0010, 8'h0, 16'h0));
		chk16(16'(lat), 16'h0004, "far latency");
		reg_rd(srre_pkg::REG_PC, rd);
		chk16(rd, 16'h3333, "far pc");
		reg_rd(srre_pkg::REG_PS, rd);
		chk16(rd, 16'h4444, "far ps");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h0614, "far sp");
		reg_wr(srre_pkg::REG_PSW, 16'h0000);
		chk16(16'(native_mode_flag), 16'h0000, "mode cleared");
		reg_wr(4'h4, 16'h0500);
		put(16'h0500, 16'h1111);
		put(16'h0502, 16'h2222);
		put(16'h0504, 16'h8001);
		run_cmd(mk(srre_pkg::OP_RET_EMU, srre_pkg::REP_ALL, 16'h0, 8'h0, 16'h0));
		chk16(16'(lat), 16'h0005, "emu latency");
		reg_rd(srre_pkg::REG_PC, rd);
		chk16(rd, 16'h1111, "emu pc");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h0506, "emu sp");
		reg_wr(srre_pkg::REG_PSW, 16'h0000);
		chk16(16'(native_mode_flag), 16'h0001, "mode locked");
		reg_rd(srre_pkg::REG_STATUS, rd);
		chk16(rd, 16'h0001, "lock status");
		@(posedge clock);
		emu_entry <= 1'b1;
		@(posedge clock);
		emu_entry <= 1'b0;
		reg_rd(srre_pkg::REG_STATUS, rd);
		chk16(rd, 16'h0003, "unlock status");
		$display("test returns done");
	endtask : t_ret

	task automatic t_prepare();
		reg_wr(4'h4, 16'h0300);
		reg_wr(4'h5, 16'h0400);
		put(16'h03fe, 16'haaaa);
		run_cmd(mk(srre_pkg::OP_PREPARE, srre_pkg::REP_ALL, 16'h0010, 8'h02, 16'h0));
		chk16(16'(lat), 16'h0005, "prepare latency");
		chk16(mem.store[16'h02fe >> 1], 16'h0400, "saved base");
		chk16(mem.store[16'h02fc >> 1], 16'haaaa, "copied frame");
		chk16(mem.store[16'h02fa >> 1], 16'h02fe, "own frame");
		reg_rd(4'h5, rd);
		chk16(rd, 16'h02fe, "prepare base");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h02ea, "prepare sp");
		reg_wr(4'h4, 16'h0300);
		reg_wr(4'h5, 16'h0400);
		run_cmd(mk(srre_pkg::OP_PREPARE, srre_pkg::REP_ALL, 16'h0010, 8'h00, 16'h0));
		chk16(16'(lat), 16'h0002, "level zero latency");
		chk16(mem.store[16'h02fe >> 1], 16'h0400, "level zero saved base");
		reg_rd(4'h5, rd);
		chk16(rd, 16'h02fe, "level zero base");
		reg_rd(4'h4, rd);
		chk16(rd, 16'h02ee, "level zero sp");
		$display("test prepare done");
	endtask : t_prepare

	task automatic rep_case(input srre_pkg::srre_rep_e rp, input logic [15:0] cnt,
		input logic cz, input logic cc, input int stop, input int steps,
		input logic [15:0] left, input logic [15:0] pc);
		cont_z = cz;
		cont_c = cc;
		stop_at = stop;
		step = 0;
		reg_wr(srre_pkg::REG_GPR_LAST - 4'h6, cnt);
		run_cmd(mk(srre_pkg::OP_REP, rp, 16'h0, 8'h0, 16'h0));
		chk16(16'(step), 16'(steps), "block steps");
		chk16(16'(irq_seen), 16'(irq_req), "interrupt taken");
		reg_rd(srre_pkg::REG_GPR_LAST - 4'h6, rd);
		chk16(rd, left, "count left");
		reg_rd(srre_pkg::REG_PC, rd);
		chk16(rd, pc, "resume pc");
	endtask : rep_case

	task automatic t_rep();
		rep_case(srre_pkg::REP_ALL, 16'h3, 1'b0, 1'b0, 2, 3, 16'h0, 16'h0102);
		rep_case(srre_pkg::REP_ALL, 16'h0, 1'b0, 1'b0, 1, 0, 16'h0, 16'h0102);
		rep_case(srre_pkg::REP_EQ, 16'h5, 1'b1, 1'b0, 3, 3, 16'h2, 16'h0102);
		rep_case(srre_pkg::REP_EQ, 16'h2, 1'b1, 1'b0, 9, 2, 16'h0, 16'h0102);
		rep_case(srre_pkg::REP_NE, 16'h5, 1'b0, 1'b1, 2, 2, 16'h3, 16'h0102);
		rep_case(srre_pkg::REP_C, 16'h5, 1'b0, 1'b1, 4, 4, 16'h1, 16'h0102);
		rep_case(srre_pkg::REP_NC, 16'h5, 1'b1, 1'b0, 1, 1, 16'h4, 16'h0102);
		@(posedge clock);
		irq_req <= 1'b1;
		rep_case(srre_pkg::REP_ALL, 16'h3, 1'b0, 1'b0, 9, 1, 16'h2, 16'h0100);
		@(posedge clock);
		irq_req <= 1'b0;
		$display("test repeat done");
	endtask : t_rep

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		irq_req = 1'b0;
		emu_entry = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		cont_z = 1'b0;
		cont_c = 1'b0;
		step = 0;
		stop_at = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_push();
		t_push_all();
		t_ret();
		t_prepare();
		t_rep();
		close_out();
	end
endmodule : stack_return_repeat_exec_test
`default_nettype wire
